// File: design/srp_chan.sv
// One shift register channel: edge detect and stage masks for its range
`timescale 1ns/1ps
module srp_chan (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic load,
  input wire logic shclk,
  input wire logic clear,
  input wire logic en,
  input wire logic [srp_pkg::REF_W-1:0] first,
  input wire logic [srp_pkg::REF_W-1:0] last,
  output logic valid,
  output logic edge_det,
  output logic [srp_pkg::IDX_W-1:0] first_idx,
  output logic [srp_pkg::NUM_STAGES-1:0] mv_mask,
  output logic [srp_pkg::NUM_STAGES-1:0] zero_mask,
  output logic [srp_pkg::NUM_STAGES-1:0] set_mask,
  output logic [srp_pkg::NUM_STAGES-1:0] clr_mask
);
  import srp_pkg::*;

  srp_chan_st_t s_ff;
  srp_chan_st_t nxt_s;
  logic [IDX_W-1:0] last_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Range check, edge detect and per-stage masks
  always_comb begin
    logic [IDX_W-1:0] iv;
    iv = '0;
    nxt_s = s_ff;
    first_idx = first[IDX_W-1:0];
    last_idx = last[IDX_W-1:0];
    // Both ends inside the pool, first not past last
    valid = en && (first >= REF_BASE) && (first <= REF_TOP) && (last >= REF_BASE) &&
            (last <= REF_TOP) && (first <= last);
    edge_det = valid && shclk && !s_ff.prev_clk;
    nxt_s.prev_clk = shclk;
    mv_mask = '0;
    zero_mask = '0;
    set_mask = '0;
    clr_mask = '0;
    for (int i = 0; i < NUM_STAGES; i++) begin
      iv = IDX_W'(i);
      if (valid && iv >= first_idx && iv <= last_idx) begin
        mv_mask[i] = edge_det && (iv > first_idx);
        zero_mask[i] = edge_det && (iv == first_idx);
        set_mask[i] = load && (iv == first_idx);
        clr_mask[i] = clear;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Previous clock level, frozen while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '{prev_clk: PREV_CLK_RST};
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Held clock gives one edge only
  property p_one_edge;
    @(posedge clk) disable iff (!rst_b)
      ce && shclk ##1 ce && shclk |-> !edge_det;
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("held clock shifted twice");
endmodule

// File: design/srp_pkg.sv
// Constants and state types shared by the retentive shift stage pool
package srp_pkg;
  // Pool geometry
  localparam int unsigned NUM_STAGES = 128;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned REF_W = 9;
  localparam int unsigned IDX_W = 7;
  // Octal references 400..577 expressed in hex
  localparam logic [8:0] REF_BASE = 9'h100;
  localparam logic [8:0] REF_TOP = 9'h17f;
  // Values after reset
  localparam logic [127:0] STAGES_RST = 128'h0;
  localparam logic PREV_CLK_RST = 1'b0;
  localparam logic RD_RST = 1'b0;
  localparam logic AERR_RST = 1'b0;

  // Whole state of the pool top
  typedef struct packed {
    logic [127:0] stages;
    logic rd;
    logic aerr;
  } srp_state_t;

  // Whole state of one shift register channel
  typedef struct packed {
    logic prev_clk;
  } srp_chan_st_t;
endpackage

// File: design/srp_pool.sv
// Pool of 128 retentive stages partitioned into up to 8 shift registers
`timescale 1ns/1ps
module srp_pool (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [srp_pkg::NUM_CH-1:0] sr_load,
  input wire logic [srp_pkg::NUM_CH-1:0] sr_clock,
  input wire logic [srp_pkg::NUM_CH-1:0] sr_clear,
  input wire logic [srp_pkg::NUM_CH-1:0] cfg_en,
  input wire logic [srp_pkg::NUM_CH-1:0][srp_pkg::REF_W-1:0] cfg_first,
  input wire logic [srp_pkg::NUM_CH-1:0][srp_pkg::REF_W-1:0] cfg_last,
  input wire logic [srp_pkg::REF_W-1:0] acc_addr,
  input wire logic acc_we,
  input wire logic acc_wdata,
  output logic [srp_pkg::NUM_STAGES-1:0] stage_q,
  output logic rd_q,
  output logic addr_err_q
);
  import srp_pkg::*;

  srp_state_t s_ff;
  srp_state_t nxt_s;
  logic [NUM_CH-1:0] ch_valid;
  logic [NUM_CH-1:0] ch_edge;
  logic [IDX_W-1:0] ch_first [NUM_CH];
  logic [NUM_STAGES-1:0] ch_mv [NUM_CH];
  logic [NUM_STAGES-1:0] ch_zero [NUM_CH];
  logic [NUM_STAGES-1:0] ch_set [NUM_CH];
  logic [NUM_STAGES-1:0] ch_clr [NUM_CH];
  logic [NUM_STAGES-1:0] mv_all;
  logic [NUM_STAGES-1:0] zero_all;
  logic [NUM_STAGES-1:0] set_all;
  logic [NUM_STAGES-1:0] clr_all;
  logic addr_ok;
  logic [IDX_W-1:0] aidx;

  ////////////////////////////////////////////////////////////////////////////
  // One channel per register, three controls each
  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    srp_chan u_chan (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .load(sr_load[k]),
      .shclk(sr_clock[k]),
      .clear(sr_clear[k]),
      .en(cfg_en[k]),
      .first(cfg_first[k]),
      .last(cfg_last[k]),
      .valid(ch_valid[k]),
      .edge_det(ch_edge[k]),
      .first_idx(ch_first[k]),
      .mv_mask(ch_mv[k]),
      .zero_mask(ch_zero[k]),
      .set_mask(ch_set[k]),
      .clr_mask(ch_clr[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Merge channel masks
  always_comb begin
    mv_all = '0;
    zero_all = '0;
    set_all = '0;
    clr_all = '0;
    for (int k = 0; k < NUM_CH; k++) begin
      mv_all = mv_all | ch_mv[k];
      zero_all = zero_all | ch_zero[k];
      set_all = set_all | ch_set[k];
      clr_all = clr_all | ch_clr[k];
    end
  end

  // Direct stage access decode
  assign addr_ok = (acc_addr >= REF_BASE) && (acc_addr <= REF_TOP);
  assign aidx = acc_addr[IDX_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state: shift, then load, then direct write, then clear
  always_comb begin
    nxt_s = s_ff;
    // Shift first so later effects see the moved data
    nxt_s.stages = (s_ff.stages & ~mv_all) |
                   ({s_ff.stages[NUM_STAGES-2:0], 1'b0} & mv_all);
    nxt_s.stages = nxt_s.stages & ~zero_all;
    nxt_s.stages = nxt_s.stages | set_all;
    if (acc_we && addr_ok) begin
      nxt_s.stages[aidx] = acc_wdata;
    end
    nxt_s.stages = nxt_s.stages & ~clr_all;
    nxt_s.rd = addr_ok ? s_ff.stages[aidx] : 1'b0;
    nxt_s.aerr = !addr_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '{stages: STAGES_RST, rd: RD_RST, aerr: AERR_RST};
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign stage_q = s_ff.stages;
  assign rd_q = s_ff.rd;
  assign addr_err_q = s_ff.aerr;

  ////////////////////////////////////////////////////////////////////////////
  // Pool holds while frozen
  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      !ce |=> $stable(stage_q);
  endproperty
  a_hold: assert property (p_hold) else $error("stages moved while frozen");

  // Read port returns the stage seen one cycle earlier
  property p_read;
    @(posedge clk) disable iff (!rst_b)
      ce && addr_ok |=> rd_q == $past(stage_q[aidx]);
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  // Out of range access flagged
  property p_aerr;
    @(posedge clk) disable iff (!rst_b)
      ce && !addr_ok |=> addr_err_q && !rd_q;
  endproperty
  a_aerr: assert property (p_aerr) else $error("bad address not flagged");

  // Direct write lands unless cleared
  property p_write;
    @(posedge clk) disable iff (!rst_b)
      ce && acc_we && addr_ok && !clr_all[aidx] |=> stage_q[$past(aidx)] == $past(acc_wdata);
  endproperty
  a_write: assert property (p_write) else $error("direct write lost");

  // Good address leaves the error flag low
  property p_addr_ok;
    @(posedge clk) disable iff (!rst_b)
      ce && addr_ok |=> !addr_err_q;
  endproperty
  a_addr_ok: assert property (p_addr_ok) else $error("good address flagged");

  // Write to a bad address changes nothing while no register acts
  property p_write_bad;
    @(posedge clk) disable iff (!rst_b)
      ce && acc_we && !addr_ok && (mv_all | zero_all | set_all | clr_all) == '0
        |=> $stable(stage_q);
  endproperty
  a_write_bad: assert property (p_write_bad) else $error("bad address write landed");

  // Per-channel checks
  for (genvar k = 0; k < NUM_CH; k++) begin : g_chk
    logic quiet;
    assign quiet = !sr_clear[k] && !acc_we;

    sequence s_shift_step;
      ce && ch_edge[k] && quiet && !sr_load[k];
    endsequence

    property p_shift;
      @(posedge clk) disable iff (!rst_b)
        (s_shift_step and (cfg_first[k] < cfg_last[k])) |=>
          stage_q[$past(ch_first[k]) + 7'h1] == $past(stage_q[ch_first[k]]);
    endproperty
    a_shift: assert property (p_shift) else $error("stage did not move on edge");

    property p_first_empty;
      @(posedge clk) disable iff (!rst_b)
        s_shift_step |=> !stage_q[$past(ch_first[k])];
    endproperty
    a_first_empty: assert property (p_first_empty) else $error("first stage kept");

    property p_load;
      @(posedge clk) disable iff (!rst_b)
        ce && ch_valid[k] && sr_load[k] && quiet |=> stage_q[$past(ch_first[k])];
    endproperty
    a_load: assert property (p_load) else $error("load did not set first stage");

    property p_load_stays;
      @(posedge clk) disable iff (!rst_b)
        ce && ch_valid[k] && stage_q[ch_first[k]] && !ch_edge[k] && quiet
          |=> stage_q[$past(ch_first[k])];
    endproperty
    a_load_stays: assert property (p_load_stays) else $error("first stage dropped");

    property p_clear;
      @(posedge clk) disable iff (!rst_b)
        ce && ch_valid[k] && sr_clear[k] |=> (stage_q & $past(ch_clr[k])) == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left a stage on");

    // Clear beats a load in the same step
    property p_clear_wins;
      @(posedge clk) disable iff (!rst_b)
        ce && ch_valid[k] && sr_clear[k] && sr_load[k] |=> !stage_q[$past(ch_first[k])];
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("load beat clear");

    // Last stage takes the one before it, its old bit dropped
    property p_last_moves;
      @(posedge clk) disable iff (!rst_b)
        (s_shift_step and (cfg_first[k] < cfg_last[k])) |=>
          stage_q[$past(cfg_last[k][IDX_W-1:0])] ==
            $past(stage_q[cfg_last[k][IDX_W-1:0] - 7'h1]);
    endproperty
    a_last_moves: assert property (p_last_moves) else $error("last stage stuck");
  end
endmodule

// File: tb/srp_pool_bench.sv
// Self-checking bench for the retentive shift stage pool
`timescale 1ns/1ps
module srp_pool_bench;
  import srp_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] rq_ld = 8'h0;
  logic [7:0] rq_ck = 8'h0;
  logic [7:0] rq_cl = 8'h0;
  logic [8:0] acc_addr = 9'h100;
  logic acc_we = 1'b0;
  logic acc_wdata = 1'b0;
  logic ce = 1'b1;
  logic lbad = 1'b0;
  logic lrd = 1'b0;
  logic [7:0] sr_load, sr_clock, sr_clear, cfg_en, pclk;
  logic [7:0][8:0] cfg_first, cfg_last;
  logic [127:0] stage_q, m;
  logic rd_q, addr_err_q;
  logic [130:0] e;
  logic [130:0] q[$];
  int err_count = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  srp_rungs rungs (.req_load(rq_ld), .req_clock(rq_ck), .req_clear(rq_cl),
    .sr_load(sr_load), .sr_clock(sr_clock), .sr_clear(sr_clear), .cfg_en(cfg_en),
    .cfg_first(cfg_first), .cfg_last(cfg_last));
  srp_pool uut (.clk(clk), .rst_b(rst_b), .ce(ce), .sr_load(sr_load),
    .sr_clock(sr_clock), .sr_clear(sr_clear), .cfg_en(cfg_en), .cfg_first(cfg_first),
    .cfg_last(cfg_last), .acc_addr(acc_addr), .acc_we(acc_we), .acc_wdata(acc_wdata),
    .stage_q(stage_q), .rd_q(rd_q), .addr_err_q(addr_err_q));
  //////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("Counts: %0d compared, %0d mismatched", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One evaluation step: drive rungs, update the model, note the result
  task automatic step(input logic [7:0] ld, ck, cl, input logic [8:0] a,
    input logic we, wd);
    logic bad;
    int f;
    int l;
    logic [127:0] pre;
    @(negedge clk);
    ce = 1'b1;
    rq_ld = ld;
    rq_ck = ck;
    rq_cl = cl;
    acc_addr = a;
    acc_we = we;
    acc_wdata = wd;
    pre = m;
    bad = (a < 9'h100) || (a > 9'h17f);
    for (int k = 0; k < 3; k++) begin
      f = cfg_first[k] - 9'h100;
      l = cfg_last[k] - 9'h100;
      if (ck[k] && !pclk[k]) begin
        for (int i = l; i > f; i--) m[i] = m[i-1];
        m[f] = 1'b0;
      end
      if (ld[k]) m[f] = 1'b1;
    end
    if (we && !bad) m[a[6:0]] = wd;
    for (int k = 0; k < 3; k++) begin
      f = cfg_first[k] - 9'h100;
      l = cfg_last[k] - 9'h100;
      if (cl[k]) for (int i = f; i <= l; i++) m[i] = 1'b0;
    end
    pclk = ck;
    lbad = bad;
    lrd = bad ? 1'b0 : pre[a[6:0]];
    q.push_back({!bad, bad, pre[a[6:0]], m});
  endtask
  // Frozen step: rungs move but ce is low, so every output must hold
  task automatic frozen(input logic [7:0] ld, ck, cl, input logic [8:0] a,
    input logic we, wd);
    @(negedge clk);
    ce = 1'b0;
    rq_ld = ld;
    rq_ck = ck;
    rq_cl = cl;
    acc_addr = a;
    acc_we = we;
    acc_wdata = wd;
    q.push_back({1'b1, lbad, lrd, m});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Take the oldest note once each result has settled
  always @(posedge clk) begin
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      check(stage_q, e[127:0]);
      check({127'h0, addr_err_q}, {127'h0, e[129]});
      if (e[130]) check({127'h0, rd_q}, {127'h0, e[128]});
    end
  end
  // Main sequence
  initial begin
    m = '0;
    pclk = '0;
    void'($urandom(20523));
    repeat (10) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    // Load, shift, held clock and idle on the twelve-stage register
    step(8'h1, 8'h0, 8'h0, 9'h11a, 1'b0, 1'b0);
    step(8'h0, 8'h1, 8'h0, 9'h11a, 1'b0, 1'b0);
    step(8'h0, 8'h1, 8'h0, 9'h11a, 1'b0, 1'b0);
    step(8'h0, 8'h0, 8'h0, 9'h11a, 1'b0, 1'b0);
    $display("Test load and shift done");
    // Clear against load and rising clock in one step
    step(8'h3, 8'h1, 8'h1, 9'h100, 1'b0, 1'b0);
    step(8'h0, 8'h0, 8'h0, 9'h100, 1'b0, 1'b0);
    $display("Test clear priority done");
    // Last stage written then dropped, bad addresses refused
    step(8'h0, 8'h0, 8'h0, 9'h17f, 1'b1, 1'b1);
    step(8'h0, 8'h4, 8'h0, 9'h17f, 1'b0, 1'b0);
    step(8'h0, 8'h0, 8'h0, 9'h180, 1'b1, 1'b1);
    step(8'h0, 8'h0, 8'h0, 9'h0ff, 1'b1, 1'b1);
    $display("Test boundaries done");
    // Frozen step with every rung active, then a normal step
    frozen(8'h7, 8'h7, 8'h7, 9'h17f, 1'b1, 1'b1);
    step(8'h0, 8'h0, 8'h0, 9'h17f, 1'b0, 1'b0);
    $display("Test clock enable done");
    // Random rung activity, direct access and frozen steps
    repeat (400) begin
      if ($urandom % 8 == 0) begin
        frozen(8'($urandom), 8'($urandom), 8'($urandom), 9'(9'h0f8 + $urandom % 144),
          1'($urandom), 1'($urandom));
      end else begin
        step(8'($urandom), 8'($urandom), 8'($urandom % 16 == 0 ? $urandom : 0),
          9'(9'h0f8 + $urandom % 144), 1'($urandom), 1'($urandom));
      end
    end
    $display("Test random done");
    @(posedge clk);
    #2;
    wrap_up();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
endmodule

// File: tb/srp_rungs.sv
// User rung logic model: fixed register layout and control levels
`timescale 1ns/1ps
module srp_rungs (
  input wire logic [7:0] req_load,
  input wire logic [7:0] req_clock,
  input wire logic [7:0] req_clear,
  output logic [7:0] sr_load,
  output logic [7:0] sr_clock,
  output logic [7:0] sr_clear,
  output logic [7:0] cfg_en,
  output logic [7:0][8:0] cfg_first,
  output logic [7:0][8:0] cfg_last
);
  // Three disjoint registers, the top one ending on the last stage
  assign cfg_en = 8'h07;
  assign cfg_first = {45'h0, 9'h160, 9'h100, 9'h119};
  assign cfg_last = {45'h0, 9'h17f, 9'h107, 9'h124};
  // Power flow reaches only defined registers
  assign sr_load = req_load & cfg_en;
  assign sr_clock = req_clock & cfg_en;
  assign sr_clear = req_clear & cfg_en;
endmodule
